/* File: logic/adc_readout_device.sv */
// Converter end of the dual simultaneous-sampling serial readout.
// Assumes chip select and serial clock come from another domain and are
// resynchronised here; the serial clock must be slow enough that each of its
// phases spans several system clocks.
// A phase shorter than one system clock could let an edge slip past unseen.
`timescale 1ns/1ps
module adc_readout_device
   import adc_link_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    ce,
   adc_link_if.device_mp                link,
   input  wire logic [RESULT_W-1:0]     analog_a,
   input  wire logic [RESULT_W-1:0]     analog_b,
   output logic                         track_mode,
   output adc_link_pkg::power_mode_t    power_mode,
   output logic                         result_ready,
   output logic                         result_invalid
);
   import adc_link_pkg::*;

   // Picks the bit due after a given number of counted falling edges.
   // Each half of a dual read is two zeros, twelve bits and two zeros.
   function automatic logic bit_at(input logic [5:0]          n,
                                   input logic [RESULT_W-1:0] own,
                                   input logic [RESULT_W-1:0] other);
      logic [3:0]          m;
      logic [RESULT_W-1:0] word;
      logic                b;
      m    = n[3:0];
      word = n[4] ? other : own;
      b    = 1'b0;
      if (m >= LEAD_ZEROS[3:0] && m < CONV_FALLS[3:0]) begin
         b = word[4'(4'hd - m)];
      end
      return b;
   endfunction : bit_at

   // Edge detection on a synchronised level and its one-cycle-delayed copy.
   function automatic logic fell_edge(input logic prev,
                                      input logic now);
      return prev & ~now;
   endfunction : fell_edge

   function automatic logic rose_edge(input logic prev,
                                      input logic now);
      return ~prev & now;
   endfunction : rose_edge

   logic                cs_s1_q, cs_s2_q, cs_p_q;
   logic                sclk_s1_q, sclk_s2_q, sclk_p_q;
   logic                active_q, active_d;
   logic [5:0]          falls_q, falls_d;
   logic                track_q, track_d;
   logic                oe_q, oe_d;
   logic                dout_a_q, dout_a_d;
   logic                dout_b_q, dout_b_d;
   logic [RESULT_W-1:0] held_a_q, held_a_d;
   logic [RESULT_W-1:0] held_b_q, held_b_d;
   power_mode_t         mode_q, mode_d;
   logic                ready_q, ready_d;
   logic                invalid_q, invalid_d;
   logic                cs_fall, cs_rise, sclk_fall, sclk_rise;
   logic [5:0]          next_falls;

   // Edges are found only on the second synchroniser stage and its delayed copy.
   assign cs_fall   = fell_edge(cs_p_q, cs_s2_q);
   assign cs_rise   = rose_edge(cs_p_q, cs_s2_q);
   assign sclk_fall = fell_edge(sclk_p_q, sclk_s2_q);
   assign sclk_rise = rose_edge(sclk_p_q, sclk_s2_q);
   assign next_falls = 6'(falls_q + 6'h01);

   // A select fall opens a frame, counted falls advance it, and a select rise
   // or the thirty-second fall closes it.
   always_comb begin
      active_d  = active_q;
      falls_d   = falls_q;
      track_d   = track_q;
      oe_d      = oe_q;
      dout_a_d  = dout_a_q;
      dout_b_d  = dout_b_q;
      held_a_d  = held_a_q;
      held_b_d  = held_b_q;
      mode_d    = mode_q;
      ready_d   = 1'b0;
      invalid_d = invalid_q;
      if (cs_fall) begin
         // A serial clock fall in this same cycle is simply not counted.
         active_d  = 1'b1;
         falls_d   = 6'h00;
         track_d   = 1'b0;
         oe_d      = 1'b1;
         dout_a_d  = 1'b0;
         dout_b_d  = 1'b0;
         held_a_d  = analog_a;
         held_b_d  = analog_b;
         // A wake-up frame still runs, but its result is not a real sample.
         invalid_d = (mode_q != PWR_NORMAL);
         if (mode_q != PWR_NORMAL) begin
            held_a_d = '0;
            held_b_d = '0;
         end
      end else if (cs_rise) begin
         active_d = 1'b0;
         oe_d     = 1'b0;
         track_d  = 1'b1;
         if (active_q && falls_q >= PD_FIRST && falls_q < PD_LAST) begin
            // Stepping down on an early release; glitches before the second
            // fall are ignored so a noisy select cannot power the part down.
            mode_d = (mode_q == PWR_NORMAL) ? PWR_PARTIAL : PWR_FULL;
         end
      end else if (active_q && sclk_fall) begin
         falls_d = next_falls;
         if (next_falls == DUAL_FALLS) begin
            active_d = 1'b0;
            oe_d     = 1'b0;
         end else begin
            // Bits 2..13 carry the result, 14 and 15 the trailing zeros,
            // and 16 onwards the other converter's word.
            dout_a_d = bit_at(next_falls, held_a_q, held_b_q);
            dout_b_d = bit_at(next_falls, held_b_q, held_a_q);
         end
         if (next_falls == PD_LAST) begin
            // The data of this wake-up frame stay marked invalid.
            mode_d = PWR_NORMAL;
         end
         if (next_falls == CONV_FALLS) begin
            // One pulse per frame that reaches the fourteenth fall, when the conversion is complete.
            ready_d = 1'b1;
         end
      end else if (active_q && sclk_rise && falls_q >= TRACK_AFTER) begin
         // Rises before the thirteenth counted fall never reach here.
         track_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         // Idle-high reset values keep the release of reset from faking an edge.
         cs_s1_q   <= 1'b1;
         cs_s2_q   <= 1'b1;
         cs_p_q    <= 1'b1;
         sclk_s1_q <= 1'b1;
         sclk_s2_q <= 1'b1;
         sclk_p_q  <= 1'b1;
         active_q  <= 1'b0;
         falls_q   <= 6'h00;
         track_q   <= 1'b1;
         oe_q      <= 1'b0;
         dout_a_q  <= 1'b0;
         dout_b_q  <= 1'b0;
         held_a_q  <= '0;
         held_b_q  <= '0;
         mode_q    <= PWR_NORMAL;
         ready_q   <= 1'b0;
         invalid_q <= 1'b0;
      end else if (ce) begin
         cs_s1_q   <= link.cs_n;
         cs_s2_q   <= cs_s1_q;
         cs_p_q    <= cs_s2_q;
         sclk_s1_q <= link.sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_p_q  <= sclk_s2_q;
         active_q  <= active_d;
         falls_q   <= falls_d;
         track_q   <= track_d;
         oe_q      <= oe_d;
         dout_a_q  <= dout_a_d;
         dout_b_q  <= dout_b_d;
         held_a_q  <= held_a_d;
         held_b_q  <= held_b_d;
         mode_q    <= mode_d;
         ready_q   <= ready_d;
         invalid_q <= invalid_d;
      end
   end

   // Both lines share one enable: the two streams always start and stop together.
   assign link.first_serial_output_o   = dout_a_q;
   assign link.first_serial_output_oe  = oe_q;
   assign link.second_serial_output_o  = dout_b_q;
   assign link.second_serial_output_oe = oe_q;
   // Status outputs come straight from flip-flops, so they never glitch.
   assign track_mode     = track_q;
   assign power_mode     = mode_q;
   assign result_ready   = ready_q;
   assign result_invalid = invalid_q;

endmodule : adc_readout_device

/* File: logic/adc_link_pkg.sv */
// Shared constants and types for the dual-converter serial readout link.
// Assumes both ends run on the same 40 MHz system clock.
package adc_link_pkg;

   localparam int          RESULT_W       = 12;
   localparam int          CLK_PERIOD_NS  = 25;
   localparam int          SCLK_PERIOD_NS = 200;
   // Half period of the serial clock that the host divides down, in system clocks.
   localparam logic [3:0]  SCLK_HALF      = 4'((SCLK_PERIOD_NS / CLK_PERIOD_NS) / 2);

   localparam logic [5:0]  LEAD_ZEROS     = 6'h02;
   localparam logic [5:0]  PD_FIRST       = 6'h02;
   localparam logic [5:0]  PD_LAST        = 6'h0a;
   localparam logic [5:0]  TRACK_AFTER    = 6'h0d;
   localparam logic [5:0]  CONV_FALLS     = 6'h0e;
   localparam logic [5:0]  WORD_FALLS     = 6'h10;
   localparam logic [5:0]  DUAL_FALLS     = 6'h20;
   localparam logic [5:0]  BURST_FALLS    = 6'h08;

   typedef enum logic [1:0] {
      PWR_NORMAL  = 2'h0,
      PWR_PARTIAL = 2'h1,
      PWR_FULL    = 2'h2
   } power_mode_t;

   typedef enum logic [1:0] {
      WL_8  = 2'h0,
      WL_14 = 2'h1,
      WL_16 = 2'h2,
      WL_32 = 2'h3
   } word_len_t;

   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_LEAD  = 3'h1,
      H_LOW   = 3'h2,
      H_HIGH  = 3'h3,
      H_TAIL  = 3'h4,
      H_QUIET = 3'h5
   } host_state_t;

   function automatic logic [5:0] falls_for(input word_len_t wl);
      logic [5:0] n;
      n = WORD_FALLS;
      case (wl)
         WL_8:    n = BURST_FALLS;
         WL_14:   n = CONV_FALLS;
         WL_16:   n = WORD_FALLS;
         default: n = DUAL_FALLS;
      endcase
      return n;
   endfunction : falls_for

endpackage : adc_link_pkg

/* File: logic/adc_link_if.sv */
// Serial link between the converter end and its host master.
// The data lines are three-state on the board; the levels are resolved here.
`timescale 1ns/1ps
interface adc_link_if;
   logic cs_n;
   logic sclk;
   logic first_serial_output_o;
   logic first_serial_output_oe;
   logic second_serial_output_o;
   logic second_serial_output_oe;
   wire  first_line;
   wire  second_line;

   // A released line shows the inverse of its last bit, so a late sample is caught.
   assign first_line  = first_serial_output_oe  ? first_serial_output_o  : ~first_serial_output_o;
   assign second_line = second_serial_output_oe ? second_serial_output_o : ~second_serial_output_o;

   modport device_mp (
      input  cs_n,
      input  sclk,
      output first_serial_output_o,
      output first_serial_output_oe,
      output second_serial_output_o,
      output second_serial_output_oe
   );

   modport host_mp (
      output cs_n,
      output sclk,
      input  first_line,
      input  second_line
   );
endinterface : adc_link_if

/* File: logic/adc_readout_host.sv */
// Host master end of the dual-converter serial readout.
// Assumes the data lines arrive asynchronously; they are resynchronised here.
// The serial clock is divided from clk and idles high between frames.
`timescale 1ns/1ps
module adc_readout_host
   import adc_link_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   adc_link_if.host_mp                link,
   input  wire logic                  start,
   input  wire adc_link_pkg::word_len_t host_word_length,
   output logic                       busy,
   output logic                       done,
   output logic [31:0]                word_a,
   output logic [31:0]                word_b
);
   import adc_link_pkg::*;

   host_state_t state_q, state_d;
   logic [3:0]  div_q, div_d;
   logic [5:0]  falls_q, falls_d;
   logic [5:0]  target_q, target_d;
   logic        cs_n_q, cs_n_d;
   logic        sclk_q, sclk_d;
   logic        done_q, done_d;
   logic [31:0] rx_a_q, rx_a_d;
   logic [31:0] rx_b_q, rx_b_d;
   logic [31:0] word_a_q, word_a_d;
   logic [31:0] word_b_q, word_b_d;
   logic        a_s1_q, a_s2_q, b_s1_q, b_s2_q;
   logic        half_over;

   assign half_over = (div_q == SCLK_HALF - 4'h1);

   always_comb begin
      state_d  = state_q;
      div_d    = half_over ? 4'h0 : 4'(div_q + 4'h1);
      falls_d  = falls_q;
      target_d = target_q;
      cs_n_d   = cs_n_q;
      sclk_d   = sclk_q;
      done_d   = 1'b0;
      rx_a_d   = rx_a_q;
      rx_b_d   = rx_b_q;
      word_a_d = word_a_q;
      word_b_d = word_b_q;
      case (state_q)
         H_IDLE: begin
            div_d = 4'h0;
            if (start) begin
               // Fixed latency from start to select, so a periodic start
               // gives equidistant samples.
               state_d  = H_LEAD;
               cs_n_d   = 1'b0;
               falls_d  = 6'h00;
               target_d = falls_for(host_word_length);
               // Each word starts from zero, so a short word is zero-filled above.
               rx_a_d   = 32'h0000_0000;
               rx_b_d   = 32'h0000_0000;
            end
         end
         H_LEAD: begin
            // A whole serial clock period passes before the first fall: the opening
            // zero takes three clocks to reach the line and two more through our
            // synchroniser, and the first fall samples it.
            if (half_over) begin
               state_d = H_HIGH;
            end
         end
         H_HIGH: begin
            if (half_over) begin
               if (falls_q == target_q) begin
                  state_d = H_TAIL;
               end else begin
                  state_d = H_LOW;
                  sclk_d  = 1'b0;
                  falls_d = 6'(falls_q + 6'h01);
                  // Sample at our own fall: the bit launched one fall earlier.
                  rx_a_d  = {rx_a_q[30:0], a_s2_q};
                  rx_b_d  = {rx_b_q[30:0], b_s2_q};
               end
            end
         end
         H_LOW: begin
            if (half_over) begin
               state_d = H_HIGH;
               sclk_d  = 1'b1;
            end
         end
         H_TAIL: begin
            if (half_over) begin
               state_d  = H_QUIET;
               cs_n_d   = 1'b1;
               done_d   = 1'b1;
               word_a_d = rx_a_q;
               word_b_d = rx_b_q;
            end
         end
         default: begin
            if (half_over) begin
               state_d = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q  <= H_IDLE;
         div_q    <= 4'h0;
         falls_q  <= 6'h00;
         target_q <= WORD_FALLS;
         cs_n_q   <= 1'b1;
         sclk_q   <= 1'b1;
         done_q   <= 1'b0;
         rx_a_q   <= 32'h0000_0000;
         rx_b_q   <= 32'h0000_0000;
         word_a_q <= 32'h0000_0000;
         word_b_q <= 32'h0000_0000;
         a_s1_q   <= 1'b0;
         a_s2_q   <= 1'b0;
         b_s1_q   <= 1'b0;
         b_s2_q   <= 1'b0;
      end else if (ce) begin
         state_q  <= state_d;
         div_q    <= div_d;
         falls_q  <= falls_d;
         target_q <= target_d;
         cs_n_q   <= cs_n_d;
         sclk_q   <= sclk_d;
         done_q   <= done_d;
         rx_a_q   <= rx_a_d;
         rx_b_q   <= rx_b_d;
         word_a_q <= word_a_d;
         word_b_q <= word_b_d;
         a_s1_q   <= link.first_line;
         a_s2_q   <= a_s1_q;
         b_s1_q   <= link.second_line;
         b_s2_q   <= b_s1_q;
      end
   end

   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign busy      = (state_q != H_IDLE);
   assign done      = done_q;
   assign word_a    = word_a_q;
   assign word_b    = word_b_q;

endmodule : adc_readout_host

/* File: bench/readout_link_sva.sv */
// Checker for the serial link between the converter end and its host master.
// Assumes it is instantiated beside the link interface and sees the raw link signals.
`timescale 1ns/1ps
module readout_link_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic first_serial_output_o,
   input wire logic first_serial_output_oe,
   input wire logic second_serial_output_o,
   input wire logic second_serial_output_oe
);
   logic       sclk_q;
   logic [5:0] falls_q;
   logic [5:0] falls_d;
   logic [3:0] since_q;
   logic [3:0] since_d;
   logic       fall;
   logic       both_zero;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   assign fall      = sclk_q & ~sclk;
   assign both_zero = ~first_serial_output_o & ~second_serial_output_o;

   // Counts serial clock falls per frame and the cycles since the latest fall.
   always_comb begin
      falls_d = falls_q;
      since_d = (since_q == 4'hf) ? since_q : since_q + 4'h1;
      if (fall) begin
         falls_d = falls_q + 6'h01;
         since_d = 4'h0;
      end
      if (cs_n) begin
         falls_d = 6'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_q  <= 1'b1;
         falls_q <= 6'h00;
         since_q <= 4'hf;
      end else begin
         sclk_q  <= sclk;
         falls_q <= falls_d;
         since_q <= since_d;
      end
   end

   chk_select_drives_lines: assert property ($fell(cs_n) |-> ##[3:5] first_serial_output_oe)
      else $error("data line not driven after select fall");
   chk_rise_floats_lines: assert property ($rose(cs_n) |-> ##[1:5] !first_serial_output_oe)
      else $error("data line still driven after select rise");
   chk_idle_stays_floating: assert property ((cs_n && $past(cs_n, 5)) |->
      !first_serial_output_oe && !second_serial_output_oe)
      else $error("data line driven while deselected");
   chk_lines_enable_together: assert property (first_serial_output_oe ==
      second_serial_output_oe)
      else $error("data line enables differ");
   chk_first_lead_zero: assert property ($rose(first_serial_output_oe) |-> both_zero)
      else $error("first leading bit not zero");
   chk_shift_on_fall: assert property (($changed(first_serial_output_o) &&
      first_serial_output_oe && $past(first_serial_output_oe)) |-> since_q == 4'h2)
      else $error("data changed away from a serial clock fall");
   chk_second_lead_zero: assert property ((!cs_n && since_q == 4'h6 && falls_q == 6'h01)
      |-> both_zero)
      else $error("second leading bit not zero");
   chk_trailing_zeros: assert property ((!cs_n && since_q == 4'h6 &&
      falls_q inside {6'h0e, 6'h0f}) |-> both_zero)
      else $error("trailing bits not zero");
   chk_second_half_zeros: assert property ((!cs_n && since_q == 4'h6 &&
      falls_q inside {6'h10, 6'h11, 6'h1e, 6'h1f}) |-> both_zero)
      else $error("zero bits of second result missing");
   chk_float_after_32: assert property ((falls_q == 6'h20 && since_q == 4'h6) |->
      !first_serial_output_oe && !second_serial_output_oe)
      else $error("data line driven after final fall");

   cover property ($rose(cs_n) && falls_q == 6'h08);
   cover property ($rose(cs_n) && falls_q == 6'h10);
   cover property (falls_q == 6'h20 && since_q == 4'h6);
endmodule : readout_link_sva

/* File: bench/dual_adc_serial_readout_test.sv */
// Testbench joining the host and converter ends of the serial readout link.
// Assumes the package, the link interface and both design ends are compiled first.
`timescale 1ns/1ps
`define check_eq(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module dual_adc_serial_readout_test;
   import adc_link_pkg::*;
   typedef struct packed {
      word_len_t           wl;
      logic [RESULT_W-1:0] a;
      logic [RESULT_W-1:0] b;
   } row_t;
   logic                clk;
   logic                rst;
   logic                start;
   logic                busy;
   logic                done;
   logic                track_mode;
   logic                result_ready;
   logic                result_invalid;
   logic                hold_seen;
   word_len_t           wl;
   power_mode_t         pmode;
   logic [RESULT_W-1:0] a_in;
   logic [RESULT_W-1:0] b_in;
   logic [31:0]         word_a;
   logic [31:0]         word_b;
   int                  error_cnt;
   int                  cmp_count;
   int                  rdy_n;
   row_t                rows [6] = '{'{WL_14, 12'hfff, 12'h000}, '{WL_16, 12'ha5a, 12'h5a5},
      '{WL_32, 12'h801, 12'h7fe}, '{WL_32, 12'h000, 12'hfff}, '{WL_16, 12'h001, 12'h800},
      '{WL_14, 12'h800, 12'h001}};

   adc_link_if link ();
   adc_readout_device u_adc_readout_device (.clk(clk), .rst(rst), .ce(1'b1), .link(link),
      .analog_a(a_in), .analog_b(b_in), .track_mode(track_mode), .power_mode(pmode),
      .result_ready(result_ready), .result_invalid(result_invalid));
   adc_readout_host u_adc_readout_host (.clk(clk), .rst(rst), .ce(1'b1), .link(link),
      .start(start), .host_word_length(wl), .busy(busy), .done(done), .word_a(word_a),
      .word_b(word_b));
   readout_link_sva u_readout_link_sva (.clk(clk), .rst(rst), .cs_n(link.cs_n),
      .sclk(link.sclk), .first_serial_output_o(link.first_serial_output_o),
      .first_serial_output_oe(link.first_serial_output_oe),
      .second_serial_output_o(link.second_serial_output_o),
      .second_serial_output_oe(link.second_serial_output_oe));

   // Host word seen for a frame: the host shifts in one launched bit per fall, LSB last.
   function automatic logic [31:0] exp_word(input word_len_t w, input logic [11:0] own,
                                            input logic [11:0] oth);
      logic [31:0] r;
      logic [11:0] v;
      int          n;
      int          m;
      r = 32'h0;
      n = (w == WL_8) ? 8 : (w == WL_14) ? 14 : (w == WL_16) ? 16 : 32;
      for (int i = 0; i < n; i++) begin
         m = i % 16;
         v = (i < 16) ? own : oth;
         r = {r[30:0], (m >= 2 && m <= 13) ? v[13-m] : 1'b0};
      end
      return r;
   endfunction : exp_word

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // One whole frame; the hold level is sampled well inside the conversion.
   task automatic run(input word_len_t w, input logic [11:0] a, input logic [11:0] b);
      int t;
      wl = w;
      a_in = a;
      b_in = b;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      rdy_n = 0;
      hold_seen = 1'b1;
      t = 0;
      while (done !== 1'b1 && t < 600) begin
         @(posedge clk);
         #1 t++;
         if (result_ready === 1'b1) rdy_n++;
         if (t == 20) hold_seen = track_mode;
      end
      if (t >= 600) error_cnt++;
      t = 0;
      while (busy !== 1'b0 && t < 20) begin
         @(posedge clk);
         #1 t++;
      end
   endtask : run

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      #(CLK_PERIOD_NS * 20000);
      error_cnt++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      start = 1'b0;
      wl = WL_16;
      a_in = 12'h000;
      b_in = 12'h000;
      error_cnt = 0;
      cmp_count = 0;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1 `check_eq(link.first_serial_output_oe, 1'b0)
      `check_eq(track_mode, 1'b1)
      `check_eq(pmode, PWR_NORMAL)
      foreach (rows[i]) begin
         run(rows[i].wl, rows[i].a, rows[i].b);
         `check_eq(word_a, exp_word(rows[i].wl, rows[i].a, rows[i].b))
         `check_eq(word_b, exp_word(rows[i].wl, rows[i].b, rows[i].a))
         `check_eq(rdy_n, 1)
         `check_eq(hold_seen, 1'b0)
         `check_eq(track_mode, 1'b1)
      end
      // Two short bursts step down twice; a long frame then powers up again.
      run(WL_8, 12'h3c3, 12'hc3c);
      `check_eq(pmode, PWR_PARTIAL)
      `check_eq(rdy_n, 0)
      run(WL_8, 12'h3c3, 12'hc3c);
      `check_eq(pmode, PWR_FULL)
      run(WL_16, 12'h123, 12'h456);
      `check_eq(word_a, 32'h0)
      `check_eq(result_invalid, 1'b1)
      `check_eq(pmode, PWR_NORMAL)
      run(WL_16, 12'h123, 12'h456);
      `check_eq(word_a, exp_word(WL_16, 12'h123, 12'h456))
      `check_eq(word_b, exp_word(WL_16, 12'h456, 12'h123))
      `check_eq(result_invalid, 1'b0)
      // A reset in mid-frame must float the lines and leave the host idle.
      wl = WL_32;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      repeat (100) @(posedge clk);
      #1 rst = 1'b1;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1 `check_eq(link.first_serial_output_oe, 1'b0)
      `check_eq(busy, 1'b0)
      `check_eq(track_mode, 1'b1)
      run(WL_32, 12'h5a5, 12'h0f0);
      `check_eq(word_a, exp_word(WL_32, 12'h5a5, 12'h0f0))
      `check_eq(word_b, exp_word(WL_32, 12'h0f0, 12'h5a5))
      stop_test();
   end
endmodule : dual_adc_serial_readout_test
